// file: dccr_pkg.sv
// dccr_pkg: register map, field positions and reset values of the dual comparator control block
// assumes a 32-bit axi4-lite register bus; comparator cores are analog and outside the logic
// Functional notes
// RULE_01 - comparator one runs when its control bit 7 is one, off when zero
// RULE_02 - comparator two runs when its control bit 7 is one, off when zero
// RULE_03 - non-inverted: comparator one result bit 6 is one when positive exceeds negative
// RULE_04 - inverted: comparator one result reads zero when positive exceeds negative, else one
// RULE_05 - comparator two result follows the same polarity rule as comparator one
// RULE_06 - bit 4 of comparator one control inverts its logical result when set
// RULE_07 - bit 4 of comparator two control inverts its logical result when set
// RULE_08 - bit 5 of comparator one control puts its result on the pin
// RULE_09 - bit 5 of comparator two control clear keeps its result internal
// RULE_10 - comparator one pin driven only with output enable, comparator enable, direction zero
// RULE_11 - comparator two pin driven only with output enable, comparator enable, direction zero
// RULE_12 - bit 2 of comparator one control selects internal reference, else positive pin
// RULE_13 - bit 2 of comparator two control selects internal reference, else positive pin
// RULE_14 - comparator one channel code selects shared negative pin of that number
// RULE_15 - comparator two channel code N selects shared negative pin N, codes 0 to 3
// RULE_16 - bit 3 of each control register ignores writes and reads zero
// RULE_17 - any read or write of a control register captures result into reference latch
// RULE_18 - mismatch flag sets on the edge of a new difference, not its level
// RULE_19 - internal result resampled every cycle; pin output passes without a latch; the code registers the pin output through one core_clk flop
// RULE_20 - reset returns both control registers to reset values, comparators off
// RULE_21 - raw comparison enters as one bit per comparator; polarity applied before sampling
package dccr_pkg;
  localparam logic [11:0] CMP1_CTRL_OFFS  = 12'h000;
  localparam logic [11:0] CMP2_CTRL_OFFS  = 12'h004;
  localparam logic [11:0] STATUS_OFFS     = 12'h008;
  localparam logic [11:0] FLAG_OFFS       = 12'h00C;
  localparam int          ENABLE_BIT      = 7;
  localparam int          RESULT_BIT      = 6;
  localparam int          PIN_DRIVE_BIT   = 5;
  localparam int          INVERT_BIT      = 4;
  localparam int          REF_SEL_BIT     = 2;
  localparam int          CHAN_LSB        = 0;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_WR_MASK    = 8'hB7;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  typedef enum logic [1:0] {
    DCCR_IDLE = 2'b00,
    DCCR_RESP = 2'b01
  } dccr_bus_state_t;
endpackage

// file: dccr_input_mux.sv
// dccr_input_mux: steering of comparator inputs for one channel, reported as one-hot selects
// assumes the analog switch matrix outside takes these one-hot selects
`timescale 1ns/1ps
module dccr_input_mux (
  // control fields
  input  wire logic [1:0] chan_sel,
  input  wire logic       ref_sel,
  // steering to the analog matrix
  output logic      [3:0] neg_pin_onehot,
  output logic            use_internal_ref
);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_neg
      // code n connects shared negative pin n [RULE_14] [RULE_15]
      assign neg_pin_onehot[g] = (chan_sel == 2'(g));
    end
  endgenerate
  assign use_internal_ref = ref_sel; // [RULE_12] [RULE_13]
endmodule

// file: dccr_mismatch.sv
// dccr_mismatch: per-comparator result sampling and mismatch edge detect
// assumes raw comparison is already a digital level synchronous to core_clk
`timescale 1ns/1ps
module dccr_mismatch (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // comparator
  input  wire logic raw_cmp,
  input  wire logic enable,
  input  wire logic invert,
  input  wire logic ctrl_access,
  // results
  output logic      result_live,
  output logic      sampled_reg,
  output logic      mismatch_edge
);
  logic ref_reg;
  logic mismatch_q_reg;
  logic mismatch;
  // disabled comparator reads low before polarity [RULE_01] [RULE_02]
  assign result_live = (raw_cmp & enable) ^ invert; // [RULE_21] [RULE_06] [RULE_07]
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sampled_reg <= 1'b0;
    end else begin
      sampled_reg <= result_live; // [RULE_19]
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ref_reg <= 1'b0;
    end else if (ctrl_access) begin
      ref_reg <= sampled_reg; // [RULE_17]
    end
  end
  assign mismatch = (sampled_reg != ref_reg) & ~ctrl_access;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mismatch_q_reg <= 1'b0;
    end else begin
      mismatch_q_reg <= mismatch;
    end
  end
  assign mismatch_edge = mismatch & ~mismatch_q_reg; // [RULE_18]
endmodule

// file: dccr_top.sv
// dccr_top: dual comparator control and status registers behind an axi4-lite slave
// assumes inputs synchronous to core_clk; raw comparisons arrive as one bit per comparator
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dccr_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog comparator cores
  input  wire logic        cmp1_raw,
  input  wire logic        cmp2_raw,
  output logic             cmp1_enable_out,
  output logic             cmp2_enable_out,
  output logic             cmp1_internal_ref_sel,
  output logic             cmp2_internal_ref_sel,
  output logic      [3:0]  cmp1_neg_sel,
  output logic      [3:0]  cmp2_neg_sel,
  // port pins
  input  wire logic        cmp1_pin_direction_bit,
  input  wire logic        cmp2_pin_direction_bit,
  output logic             cmp1_pin_out,
  output logic             cmp1_pin_oe,
  output logic             cmp2_pin_out,
  output logic             cmp2_pin_oe,
  // mismatch event toward interrupt logic
  output logic             cmp1_mismatch,
  output logic             cmp2_mismatch
);
  logic [7:0]  ctrl1_reg;
  logic [7:0]  ctrl2_reg;
  logic [1:0]  flag_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  dccr_pkg::dccr_bus_state_t wr_state_reg;
  dccr_pkg::dccr_bus_state_t rd_state_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic        acc1;
  logic        acc2;
  logic        live1;
  logic        live2;
  logic        samp1;
  logic        samp2;
  logic        edge1;
  logic        edge2;
  logic [3:0]  neg1;
  logic [3:0]  neg2;
  logic        iref1;
  logic        iref2;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;

  // write path: address and data taken in either order
  assign wr_fire = aw_held_reg & w_held_reg & (wr_state_reg == dccr_pkg::DCCR_IDLE);
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_reg   <= 1'b0;
      awaddr_reg    <= 12'h000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid & s_axi_awready) begin
      aw_held_reg   <= 1'b1;
      awaddr_reg    <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held_reg   <= 1'b0;
    end else if (!aw_held_reg && wr_state_reg == dccr_pkg::DCCR_IDLE) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      w_held_reg   <= 1'b0;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid & s_axi_wready) begin
      w_held_reg   <= 1'b1;
      wdata_reg    <= s_axi_wdata;
      wstrb_reg    <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held_reg   <= 1'b0;
    end else if (!w_held_reg && wr_state_reg == dccr_pkg::DCCR_IDLE) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_state_reg <= dccr_pkg::DCCR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dccr_pkg::RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        dccr_pkg::DCCR_IDLE: begin
          if (wr_fire) begin
            wr_state_reg <= dccr_pkg::DCCR_RESP;
            s_axi_bvalid <= 1'b1;
            unique case (awaddr_reg)
              dccr_pkg::CMP1_CTRL_OFFS,
              dccr_pkg::CMP2_CTRL_OFFS,
              dccr_pkg::STATUS_OFFS,
              dccr_pkg::FLAG_OFFS: s_axi_bresp <= dccr_pkg::RESP_OKAY;
              default:             s_axi_bresp <= dccr_pkg::RESP_SLVERR;
            endcase
          end
        end
        dccr_pkg::DCCR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= dccr_pkg::DCCR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_state_reg <= dccr_pkg::DCCR_IDLE;
      endcase
    end
  end

  // control registers; bit 6 and bit 3 never stored [RULE_16] [RULE_20]
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_reg <= dccr_pkg::CTRL_RESET;
    end else if (wr_fire && awaddr_reg == dccr_pkg::CMP1_CTRL_OFFS && wstrb_reg[0]) begin
      ctrl1_reg <= wdata_reg[7:0] & dccr_pkg::CTRL_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl2_reg <= dccr_pkg::CTRL_RESET;
    end else if (wr_fire && awaddr_reg == dccr_pkg::CMP2_CTRL_OFFS && wstrb_reg[0]) begin
      ctrl2_reg <= wdata_reg[7:0] & dccr_pkg::CTRL_WR_MASK;
    end
  end

  // register reads and writes both count as a read of the control register
  assign acc1 = (wr_fire && awaddr_reg == dccr_pkg::CMP1_CTRL_OFFS)
             || (rd_fire && s_axi_araddr == dccr_pkg::CMP1_CTRL_OFFS); // [RULE_17]
  assign acc2 = (wr_fire && awaddr_reg == dccr_pkg::CMP2_CTRL_OFFS)
             || (rd_fire && s_axi_araddr == dccr_pkg::CMP2_CTRL_OFFS); // [RULE_17]

  dccr_mismatch u_mm1 (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .raw_cmp       (cmp1_raw),
    .enable        (ctrl1_reg[dccr_pkg::ENABLE_BIT]),
    .invert        (ctrl1_reg[dccr_pkg::INVERT_BIT]),
    .ctrl_access   (acc1),
    .result_live   (live1),
    .sampled_reg   (samp1),
    .mismatch_edge (edge1)
  );

  dccr_mismatch u_mm2 (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .raw_cmp       (cmp2_raw),
    .enable        (ctrl2_reg[dccr_pkg::ENABLE_BIT]),
    .invert        (ctrl2_reg[dccr_pkg::INVERT_BIT]),
    .ctrl_access   (acc2),
    .result_live   (live2),
    .sampled_reg   (samp2),
    .mismatch_edge (edge2)
  );

  dccr_input_mux u_mux1 (
    .chan_sel         (ctrl1_reg[dccr_pkg::CHAN_LSB +: 2]),
    .ref_sel          (ctrl1_reg[dccr_pkg::REF_SEL_BIT]),
    .neg_pin_onehot   (neg1),
    .use_internal_ref (iref1)
  );

  dccr_input_mux u_mux2 (
    .chan_sel         (ctrl2_reg[dccr_pkg::CHAN_LSB +: 2]),
    .ref_sel          (ctrl2_reg[dccr_pkg::REF_SEL_BIT]),
    .neg_pin_onehot   (neg2),
    .use_internal_ref (iref2)
  );

  // sticky mismatch flags; set wins over a software clear of the same bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0) ? edge1 : edge2) begin
          flag_reg[i] <= 1'b1; // [RULE_18]
        end else if (wr_fire && awaddr_reg == dccr_pkg::FLAG_OFFS && wstrb_reg[0]
                     && wdata_reg[i]) begin
          flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // analog control outputs and mismatch events, one flop after the control register and the edge detect
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmp1_enable_out       <= 1'b0;
      cmp2_enable_out       <= 1'b0;
      cmp1_internal_ref_sel <= 1'b0;
      cmp2_internal_ref_sel <= 1'b0;
      cmp1_neg_sel          <= 4'h0;
      cmp2_neg_sel          <= 4'h0;
      cmp1_mismatch         <= 1'b0;
      cmp2_mismatch         <= 1'b0;
    end else begin
      cmp1_enable_out       <= ctrl1_reg[dccr_pkg::ENABLE_BIT]; // [RULE_01]
      cmp2_enable_out       <= ctrl2_reg[dccr_pkg::ENABLE_BIT]; // [RULE_02]
      cmp1_internal_ref_sel <= iref1; // [RULE_12]
      cmp2_internal_ref_sel <= iref2; // [RULE_13]
      cmp1_neg_sel          <= neg1; // [RULE_14]
      cmp2_neg_sel          <= neg2; // [RULE_15]
      cmp1_mismatch         <= edge1;
      cmp2_mismatch         <= edge2;
    end
  end

  // pin override uses the live result, not the sampled one
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmp1_pin_out <= 1'b0;
      cmp1_pin_oe  <= 1'b0;
      cmp2_pin_out <= 1'b0;
      cmp2_pin_oe  <= 1'b0;
    end else begin
      cmp1_pin_out <= live1; // [RULE_19]
      cmp2_pin_out <= live2;
      cmp1_pin_oe  <= ctrl1_reg[dccr_pkg::PIN_DRIVE_BIT] & ctrl1_reg[dccr_pkg::ENABLE_BIT]
                      & ~cmp1_pin_direction_bit; // [RULE_08] [RULE_10]
      cmp2_pin_oe  <= ctrl2_reg[dccr_pkg::PIN_DRIVE_BIT] & ctrl2_reg[dccr_pkg::ENABLE_BIT]
                      & ~cmp2_pin_direction_bit; // [RULE_09] [RULE_11]
    end
  end

  // read mux: result bit is the sampled, polarity-applied value
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = dccr_pkg::RESP_OKAY;
    unique case (s_axi_araddr)
      dccr_pkg::CMP1_CTRL_OFFS: begin
        rd_word[7:0] = ctrl1_reg;
        rd_word[dccr_pkg::RESULT_BIT] = samp1; // [RULE_03] [RULE_04]
      end
      dccr_pkg::CMP2_CTRL_OFFS: begin
        rd_word[7:0] = ctrl2_reg;
        rd_word[dccr_pkg::RESULT_BIT] = samp2; // [RULE_05]
      end
      dccr_pkg::STATUS_OFFS: begin
        rd_word[1:0] = {samp2, samp1};
      end
      dccr_pkg::FLAG_OFFS: begin
        rd_word[1:0] = flag_reg;
      end
      default: rd_resp = dccr_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_state_reg  <= dccr_pkg::DCCR_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= dccr_pkg::RESP_OKAY;
    end else begin
      unique case (rd_state_reg)
        dccr_pkg::DCCR_IDLE: begin
          if (rd_fire) begin
            rd_state_reg  <= dccr_pkg::DCCR_RESP;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_resp;
          end
        end
        dccr_pkg::DCCR_RESP: begin
          if (s_axi_rready) begin
            rd_state_reg  <= dccr_pkg::DCCR_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
          end
        end
        default: rd_state_reg <= dccr_pkg::DCCR_IDLE;
      endcase
    end
  end
endmodule

// file: dccr_assertions.sv
// dccr_assertions: port-level checks of the dual comparator control block
// assumes one clock core_clk, reset nrst async active low; bound to dccr_top
`timescale 1ns/1ps
module dccr_assertions (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // comparator steering
  input wire logic        cmp1_enable_out,
  input wire logic        cmp2_enable_out,
  input wire logic [3:0]  cmp1_neg_sel,
  input wire logic [3:0]  cmp2_neg_sel,
  // pins and events
  input wire logic        cmp1_pin_direction_bit,
  input wire logic        cmp2_pin_direction_bit,
  input wire logic        cmp1_pin_oe,
  input wire logic        cmp2_pin_oe,
  input wire logic        cmp1_mismatch,
  input wire logic        cmp2_mismatch
);
  default clocking dccr_cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_oe1_gate: assert property (
    cmp1_pin_oe |-> cmp1_enable_out && !$past(cmp1_pin_direction_bit))
    else $error("pin one driven without enable or output direction");
  a_oe2_gate: assert property (
    cmp2_pin_oe |-> cmp2_enable_out && !$past(cmp2_pin_direction_bit))
    else $error("pin two driven without enable or output direction");
  a_chan_onehot: assert property (
    $past(nrst) |-> $onehot(cmp1_neg_sel) && $onehot(cmp2_neg_sel))
    else $error("negative input select not one-hot");
  a_mm_pulse: assert property (
    cmp1_mismatch |=> !cmp1_mismatch)
    else $error("mismatch one held longer than one cycle");
  a_mm2_pulse: assert property (
    cmp2_mismatch |=> !cmp2_mismatch)
    else $error("mismatch two held longer than one cycle");
  a_rst_off: assert property (
    $rose(nrst) |-> !cmp1_enable_out && !cmp2_enable_out && !cmp1_pin_oe && !cmp2_pin_oe)
    else $error("comparator active right after reset");
  a_rd_unused: assert property (
    s_axi_rvalid |-> s_axi_rdata[3] == 1'b0 && s_axi_rdata[31:8] == 24'h0)
    else $error("read data has unimplemented bits set");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready |-> ##[1:20] s_axi_bvalid)
    else $error("write response missing");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_r_release: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released after rready");
  a_b_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released after bready");

  c_write: cover property (s_axi_awvalid && s_axi_awready);
  c_read: cover property (s_axi_arvalid && s_axi_arready);
  c_mm: cover property (cmp1_mismatch);
  c_mm2: cover property (cmp2_mismatch);
endmodule

bind dccr_top dccr_assertions i_dccr_assertions (
  .core_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .cmp1_enable_out, .cmp2_enable_out, .cmp1_neg_sel, .cmp2_neg_sel,
  .cmp1_pin_direction_bit, .cmp2_pin_direction_bit, .cmp1_pin_oe, .cmp2_pin_oe,
  .cmp1_mismatch, .cmp2_mismatch
);

// file: testbench.sv
// testbench: register, pin and mismatch checks of dccr_top over axi4-lite
// assumes dccr_top alone; the bench drives every port itself
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] wd; logic raw; logic dir; logic [7:0] rb; logic oe;} dccr_row_t;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hF, cmp1_neg_sel, cmp2_neg_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmp1_raw = 1'b0, cmp2_raw = 1'b0;
  logic        cmp1_pin_direction_bit = 1'b0, cmp2_pin_direction_bit = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        cmp1_enable_out, cmp2_enable_out, cmp1_internal_ref_sel, cmp2_internal_ref_sel;
  logic        cmp1_pin_out, cmp1_pin_oe, cmp2_pin_out, cmp2_pin_oe, cmp1_mismatch, cmp2_mismatch;
  int          errors = 0, check_count = 0, mc1 = 0, m = 0, mc2 = 0, m2 = 0;
  // written byte, raw level, direction, expected readback, expected pin drive
  dccr_row_t   rows [8] = '{'{8'hFF, 1'b1, 1'b0, 8'hB7, 1'b1}, '{8'hA4, 1'b1, 1'b0, 8'hE4, 1'b1},
    '{8'hB1, 1'b0, 1'b0, 8'hF1, 1'b1}, '{8'hA2, 1'b1, 1'b1, 8'hE2, 1'b0},
    '{8'h33, 1'b1, 1'b0, 8'h73, 1'b0}, '{8'h08, 1'b0, 1'b0, 8'h00, 1'b0},
    '{8'h80, 1'b0, 1'b0, 8'h80, 1'b0}, '{8'hC0, 1'b0, 1'b0, 8'h80, 1'b0}};

  dccr_top i_dccr_top (
    .core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cmp1_raw, .cmp2_raw, .cmp1_enable_out, .cmp2_enable_out,
    .cmp1_internal_ref_sel, .cmp2_internal_ref_sel, .cmp1_neg_sel, .cmp2_neg_sel,
    .cmp1_pin_direction_bit, .cmp2_pin_direction_bit, .cmp1_pin_out, .cmp1_pin_oe,
    .cmp2_pin_out, .cmp2_pin_oe, .cmp1_mismatch, .cmp2_mismatch
  );

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (cmp1_mismatch === 1'b1) mc1 <= mc1 + 1;
  always @(posedge core_clk) if (cmp2_mismatch === 1'b1) mc2 <= mc2 + 1;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out;
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    chk("bvalid", 32'h1, 32'(s_axi_bvalid));
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    chk("rvalid", 32'h1, 32'(s_axi_rvalid));
    rv = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
    @(posedge core_clk);
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i]) begin
      cmp1_raw <= rows[i].raw;
      cmp2_raw <= rows[i].raw;
      cmp1_pin_direction_bit <= rows[i].dir;
      cmp2_pin_direction_bit <= rows[i].dir;
      wr(12'h000, rows[i].wd, 2'h0);
      wr(12'h004, rows[i].wd, 2'h0);
      rd(12'h000, 2'h0);
      chk("ctrl1", 32'(rows[i].rb), rv);
      rd(12'h004, 2'h0);
      chk("ctrl2", 32'(rows[i].rb), rv);
      chk("en", 32'({2{rows[i].wd[7]}}), 32'({cmp1_enable_out, cmp2_enable_out}));
      chk("ref", 32'({2{rows[i].wd[2]}}), 32'({cmp1_internal_ref_sel, cmp2_internal_ref_sel}));
      chk("neg", 32'({2{4'(4'h1 << rows[i].wd[1:0])}}), 32'({cmp1_neg_sel, cmp2_neg_sel}));
      chk("oe", 32'({2{rows[i].oe}}), 32'({cmp1_pin_oe, cmp2_pin_oe}));
      chk("pin", 32'({2{rows[i].rb[6]}}), 32'({cmp1_pin_out, cmp2_pin_out}));
    end
    // edge, not level, of a new difference raises the event
    wr(12'h000, 8'h80, 2'h0);
    m = mc1;
    m2 = mc2;
    cmp1_raw <= 1'b1;
    cmp2_raw <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("mm rise", 32'(m + 1), 32'(mc1));
    chk("mm2 rise", 32'(m2 + 1), 32'(mc2));
    cmp1_raw <= 1'b0;
    cmp2_raw <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk("mm back", 32'(m + 1), 32'(mc1));
    chk("mm2 back", 32'(m2 + 1), 32'(mc2));
    rd(12'h00C, 2'h0);
    chk("flag", 32'h3, 32'(rv[1:0]));
    wr(12'h00C, 8'h03, 2'h0);
    rd(12'h00C, 2'h0);
    chk("flag clr", 32'h0, rv);
    cmp1_raw <= 1'b1;
    cmp2_raw <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(12'h008, 2'h0);
    chk("status", 32'h3, rv);
    rd(12'h000, 2'h0);
    cmp1_raw <= 1'b0;
    cmp2_raw <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk("mm read", 32'(m + 3), 32'(mc1));
    chk("mm2 keep", 32'(m2 + 2), 32'(mc2));
    // unmapped accesses and a write without strobe bit 0 leave the registers alone
    rd(12'h010, 2'h2);
    chk("unmapped", 32'h0, rv);
    wr(12'h010, 8'hFF, 2'h2);
    s_axi_wstrb <= 4'hE;
    wr(12'h000, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(12'h000, 2'h0);
    chk("strb", 32'h80, rv);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(12'h000, 2'h0);
    chk("rst1", 32'h0, rv);
    rd(12'h004, 2'h0);
    chk("rst2", 32'h0, rv);
    chk("rst en", 32'h0, 32'({cmp1_enable_out, cmp2_enable_out}));
    close_out();
  end

  initial begin
    #100us;
    errors++;
    close_out();
  end
endmodule
